// ### rtl/uart_status_control.sv
// Purpose: Status flags, interrupt request and first control register of the serial port.
// Assumes: Shifters, baud logic and second control register sit outside on clk_i.
// Notes:   Flags clear only by a status read followed by a data access.
//
// Overview of operation
// - Any enabled serial event wakes the core out of Wait.
// - In Halt the link stops and no event wakes the core.
// - All events but noise and framing share one request, gated by enables and global unmask.
// - Status register is read only, bits as listed, reset C0h.
// - Tx empty sets on load into shifter; status then data write clears.
// - Holding word is not loaded while tx empty flag is set.
// - Tx done sets after a data frame, not preamble or break.
// - Rx full sets when a word lands; status then data read clears.
// - Quiet line sets on idle, re-armed only by a new rx full.
// - Overrun sets when a word completes while rx full is set.
// - On overrun the unread word is kept, the new one dropped.
// - Noise flag sets on noisy frame and raises no interrupt.
// - Framing sets without interrupt; with overrun only overrun shows.
// - Parity error sets on failed check; interrupt when enabled.
// - Nine-bit mode stores rx ninth bit and sends tx ninth bit.
// - Low power bit stops link after the current byte.
// - Word length bit selects eight or nine data bits.
// - Wake bit selects idle line or address mark wake-up.
// - Parity enable inserts and checks parity at the MSB, after current byte.
// - Parity select picks even or odd, after current byte.
// - Control bit 0 enables the parity error interrupt.
// - Rx enable requests on overrun or rx full.
`timescale 1ns/1ns
`include "uart_status_control_regs.svh"

module uart_status_control #(
	parameter int ADDR_W = 2
) (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	input  wire logic              tx_empty_irq_enable_i,
	input  wire logic              tx_done_irq_enable_i,
	input  wire logic              rx_irq_enable_i,
	input  wire logic              quiet_line_irq_enable_i,
	input  wire logic              global_irq_unmask_i,
	input  wire logic              wait_mode_i,
	input  wire logic              halt_mode_i,
	input  wire logic              tx_busy_i,
	input  wire logic              rx_busy_i,
	input  wire logic              shift_ready_i,
	output logic                   shift_load_o,
	output logic      [8:0]        shift_word_o,
	input  wire logic              tx_frame_done_i,
	input  wire logic              tx_frame_data_i,
	input  wire logic              rx_word_valid_i,
	input  wire logic [8:0]        rx_word_i,
	input  wire logic              rx_noise_i,
	input  wire logic              rx_framing_i,
	input  wire logic              idle_line_i,
	output logic                   word_nine_o,
	output logic                   wake_address_mark_o,
	output logic                   parity_enable_o,
	output logic                   parity_odd_select_o,
	output logic                   link_stop_o,
	output logic                   irq_o,
	output logic                   wake_o
);

	// ==========================================================
	// Elaboration check
	if (ADDR_W < 2) begin : g_bad_addr
		$error("ADDR_W must be at least 2");
	end

	// ==========================================================
	// Functions
	function automatic uart_status_control_pkg::reg_sel_t
		decode(input logic [ADDR_W-1:0] a);
		uart_status_control_pkg::reg_sel_t s;
		s = uart_status_control_pkg::SEL_NONE;
		if (a == ADDR_W'(`OFS_STATUS)) begin
			s = uart_status_control_pkg::SEL_STATUS;
		end else if (a == ADDR_W'(`OFS_DATA)) begin
			s = uart_status_control_pkg::SEL_DATA;
		end else if (a == ADDR_W'(`OFS_CTRL_ONE)) begin
			s = uart_status_control_pkg::SEL_CTRL;
		end
		return s;
	endfunction

	// Xor of the data field: 8 LSBs in nine-bit mode, 7 otherwise
	function automatic logic data_xor(input logic [8:0] w, input logic nine);
		logic x;
		x = ^w[6:0];
		if (nine) begin
			x = x ^ w[7];
		end
		return x;
	endfunction

	// ==========================================================
	// State
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] tx_hold_q;
	logic [7:0] rx_hold_q;
	logic [7:0] rdata_q;
	logic [8:0] word_q;
	logic       load_q;
	logic       seen_q;
	logic       armed_q;
	logic       nine_q;
	logic       par_en_q;
	logic       par_odd_q;
	logic       stop_q;

	// ==========================================================
	// Bus decode
	uart_status_control_pkg::reg_sel_t sel;
	wire logic st_rd;
	wire logic dt_rd;
	wire logic dt_wr;
	wire logic c1_wr;
	wire logic clr_tx;
	wire logic clr_rx;

	assign sel   = decode(addr_i);
	assign st_rd = rd_i && (sel == uart_status_control_pkg::SEL_STATUS);
	assign dt_rd = rd_i && (sel == uart_status_control_pkg::SEL_DATA);
	assign dt_wr = wr_i && (sel == uart_status_control_pkg::SEL_DATA);
	assign c1_wr = wr_i && (sel == uart_status_control_pkg::SEL_CTRL);
	assign clr_tx = dt_wr && seen_q;
	assign clr_rx = dt_rd && seen_q;

	// ==========================================================
	// Format and link control
	wire logic idle_both;
	wire logic stop_d;

	assign idle_both = !tx_busy_i && !rx_busy_i;
	// low power stop waits for the byte in progress
	assign stop_d = ctrl_q[`C1_LOW_POWER] && (stop_q || idle_both);

	// ==========================================================
	// Transmit side
	wire logic       load_go;
	wire logic       tx_done_set;
	logic      [8:0] tx_fmt;

	// load only once the empty flag is clear
	assign load_go = !status_q[`ST_TX_EMPTY] && shift_ready_i && !link_stop_o
		&& !load_q;
	assign tx_done_set = tx_frame_done_i && tx_frame_data_i;

	always_comb begin
		tx_fmt = {ctrl_q[`C1_TX_NINTH] && nine_q, tx_hold_q};
		if (par_en_q) begin
			if (nine_q) begin
				tx_fmt[8] = data_xor(tx_fmt, 1'b1) ^ par_odd_q;
			end else begin
				tx_fmt[7] = data_xor(tx_fmt, 1'b0) ^ par_odd_q;
			end
		end
	end

	// ==========================================================
	// Receive side
	wire logic rx_ok;
	wire logic rx_take;
	wire logic rx_over;
	wire logic rx_pbit;
	wire logic rx_perr;
	wire logic quiet_set;

	assign rx_ok   = rx_word_valid_i && !link_stop_o;
	assign rx_over = rx_ok && status_q[`ST_RX_FULL];
	assign rx_take = rx_ok && !status_q[`ST_RX_FULL];
	assign rx_pbit = nine_q ? rx_word_i[8] : rx_word_i[7];
	assign rx_perr = par_en_q
		&& ((data_xor(rx_word_i, nine_q) ^ rx_pbit) != par_odd_q);
	assign quiet_set = idle_line_i && armed_q && !link_stop_o;

	// ==========================================================
	// Status next value, set wins over clear
	always_comb begin
		status_d = status_q;
		if (clr_tx) begin
			status_d[`ST_TX_EMPTY] = 1'b0;
			status_d[`ST_TX_DONE]  = 1'b0;
		end
		if (clr_rx) begin
			status_d[`ST_RX_FULL] = 1'b0;
			status_d[`ST_QUIET]   = 1'b0;
			status_d[`ST_OVERRUN] = 1'b0;
			status_d[`ST_NOISE]   = 1'b0;
			status_d[`ST_FRAMING] = 1'b0;
		end
		if (clr_tx || clr_rx) begin
			status_d[`ST_PARITY] = 1'b0;
		end
		if (load_go) begin
			status_d[`ST_TX_EMPTY] = 1'b1;
		end
		if (tx_done_set) begin
			status_d[`ST_TX_DONE] = 1'b1;
		end
		if (rx_take) begin
			status_d[`ST_RX_FULL] = 1'b1;
			if (rx_noise_i) begin
				status_d[`ST_NOISE] = 1'b1;
			end
			if (rx_framing_i) begin
				status_d[`ST_FRAMING] = 1'b1;
			end
			if (rx_perr) begin
				status_d[`ST_PARITY] = 1'b1;
			end
		end
		if (rx_over) begin
			status_d[`ST_OVERRUN] = 1'b1;
		end
		if (quiet_set) begin
			status_d[`ST_QUIET] = 1'b1;
		end
	end

	// ==========================================================
	// Control one next value
	always_comb begin
		ctrl_d = ctrl_q;
		// Bit 7 is hardware owned
		if (c1_wr) begin
			ctrl_d[6:0] = wdata_i[6:0];
		end
		if (rx_take && nine_q) begin
			ctrl_d[`C1_RX_NINTH] = rx_word_i[8];
		end
	end

	// ==========================================================
	// Read mux
	logic [7:0] rd_mux;

	always_comb begin
		case (sel)
			uart_status_control_pkg::SEL_STATUS: rd_mux = status_q;
			uart_status_control_pkg::SEL_DATA:   rd_mux = rx_hold_q;
			uart_status_control_pkg::SEL_CTRL:   rd_mux = ctrl_q;
			default:                              rd_mux = 8'h00;
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			status_q <= `STATUS_RESET;
			ctrl_q   <= `CTRL_RESET;
		end else begin
			status_q <= status_d;
			ctrl_q   <= ctrl_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_q <= 8'h00;
			seen_q  <= 1'b0;
		end else begin
			rdata_q <= rd_i ? rd_mux : 8'h00;
			// status read arms, data access consumes
			if (st_rd) begin
				seen_q <= 1'b1;
			end else if (dt_rd || dt_wr) begin
				seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_hold_q <= `DATA_RESET;
			rx_hold_q <= `DATA_RESET;
		end else begin
			if (dt_wr) begin
				tx_hold_q <= wdata_i;
			end
			// holding register only written when free
			if (rx_take) begin
				rx_hold_q <= rx_word_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			word_q <= 9'h000;
			load_q <= 1'b0;
		end else begin
			load_q <= load_go;
			if (load_go) begin
				word_q <= tx_fmt;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			armed_q <= 1'b0;
		end else if (rx_take) begin
			armed_q <= 1'b1;
		end else if (quiet_set) begin
			armed_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			nine_q    <= 1'b0;
			par_en_q  <= 1'b0;
			par_odd_q <= 1'b0;
			stop_q    <= 1'b0;
		end else begin
			if (idle_both) begin
				nine_q    <= ctrl_q[`C1_WORD_NINE];
				par_en_q  <= ctrl_q[`C1_PAR_EN];
				par_odd_q <= ctrl_q[`C1_PAR_ODD];
			end
			stop_q <= stop_d;
		end
	end

	// ==========================================================
	// Interrupt request
	wire logic req;

	assign req = (tx_empty_irq_enable_i && status_q[`ST_TX_EMPTY])
		|| (tx_done_irq_enable_i && status_q[`ST_TX_DONE])
		|| (rx_irq_enable_i && (status_q[`ST_RX_FULL] || status_q[`ST_OVERRUN]))
		|| (quiet_line_irq_enable_i && status_q[`ST_QUIET])
		|| (ctrl_q[`C1_PAR_IRQ] && status_q[`ST_PARITY]);

	assign irq_o = req && global_irq_unmask_i && !halt_mode_i;
	// wake from Wait; never from Halt
	assign wake_o = req && wait_mode_i && !halt_mode_i;

	// ==========================================================
	// Outputs
	assign rdata_o      = rdata_q;
	assign shift_load_o = load_q;
	assign shift_word_o = word_q;
	assign word_nine_o         = nine_q;
	assign wake_address_mark_o = ctrl_q[`C1_WAKE_MARK];
	assign parity_enable_o     = par_en_q;
	assign parity_odd_select_o = par_odd_q;
	assign link_stop_o = stop_q || halt_mode_i;

endmodule // uart_status_control

// ### rtl/uart_status_control_regs.svh
// Purpose: Register offsets, bit positions and reset values of the serial status block.
// Assumes: Register index equals port address.
// Notes:   Definitions only.
`ifndef UART_STATUS_CONTROL_REGS_SVH
`define UART_STATUS_CONTROL_REGS_SVH

// ==========================================================
// Register offsets
`define OFS_STATUS    2'h0
`define OFS_DATA      2'h1
`define OFS_CTRL_ONE  2'h2

// ==========================================================
// Status bits
`define ST_TX_EMPTY   7
`define ST_TX_DONE    6
`define ST_RX_FULL    5
`define ST_QUIET      4
`define ST_OVERRUN    3
`define ST_NOISE      2
`define ST_FRAMING    1
`define ST_PARITY     0

// ==========================================================
// Control one bits
`define C1_RX_NINTH   7
`define C1_TX_NINTH   6
`define C1_LOW_POWER  5
`define C1_WORD_NINE  4
`define C1_WAKE_MARK  3
`define C1_PAR_EN     2
`define C1_PAR_ODD    1
`define C1_PAR_IRQ    0

// ==========================================================
// Reset values
`define STATUS_RESET  8'hC0
`define CTRL_RESET    8'h00
`define DATA_RESET    8'h00

`endif

// ### rtl/uart_status_control_pkg.sv
// Purpose: Types shared by the serial status block.
// Assumes: Constants live in uart_status_control_regs.svh.
// Notes:   Nothing is imported; use the scoped names.
package uart_status_control_pkg;

	// ==========================================================
	// Register select
	typedef enum logic [1:0] {
		SEL_STATUS = 2'b00,
		SEL_DATA   = 2'b01,
		SEL_CTRL   = 2'b10,
		SEL_NONE   = 2'b11
	} reg_sel_t;

endpackage

// ### verif/uart_status_control_checker.sv
// Purpose: Port assertions for the serial status block.
// Assumes: Offsets and bits come from uart_status_control_regs.svh.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ns
`include "uart_status_control_regs.svh"

module uart_status_control_checker #(
	parameter int ADDR_W = 2
) (
	input wire logic              clk_i,
	input wire logic              reset_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0]        wdata_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [7:0]        rdata_o,
	input wire logic              global_irq_unmask_i,
	input wire logic              wait_mode_i,
	input wire logic              halt_mode_i,
	input wire logic              shift_ready_i,
	input wire logic              shift_load_o,
	input wire logic              rx_word_valid_i,
	input wire logic              link_stop_o,
	input wire logic              irq_o,
	input wire logic              wake_o
);
	default clocking dclk @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// ==========================================
	// Bus steps
	sequence stat_rd;
		rd_i && addr_i == `OFS_STATUS;
	endsequence
	sequence no_acc;
		!rd_i && !wr_i;
	endsequence
	sequence arm_write;
		stat_rd ##1 no_acc ##1 wr_i && addr_i == `OFS_DATA;
	endsequence
	sequence word_seen;
		rx_word_valid_i && !link_stop_o && !rd_i && !wr_i ##1 no_acc ##1 stat_rd;
	endsequence
	sequence ctl_wr_rd;
		wr_i && addr_i == `OFS_CTRL_ONE ##1 no_acc ##1 rd_i && addr_i == `OFS_CTRL_ONE;
	endsequence

	// ==========================================
	// Assertions
	read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	read_unmapped_a: assert property (rd_i && addr_i == 2'h3 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	ctrl_readback_a: assert property (ctl_wr_rd |=> rdata_o[6:0] == $past(wdata_i[6:0], 3))
		else $error("control readback differs");
	tx_load_a: assert property (arm_write ##1 (shift_ready_i && !link_stop_o && !shift_load_o)
		|=> shift_load_o)
		else $error("no load after clear sequence");
	load_gap_a: assert property (shift_load_o |=> !shift_load_o)
		else $error("load pulse longer than one cycle");
	load_cause_a: assert property (shift_load_o |-> $past(shift_ready_i) && !$past(link_stop_o))
		else $error("load without ready or while stopped");
	rx_full_a: assert property (word_seen |=> rdata_o[`ST_RX_FULL])
		else $error("rx full not set after a word");
	irq_mask_a: assert property (!global_irq_unmask_i |-> !irq_o)
		else $error("request while masked");
	halt_quiet_a: assert property (halt_mode_i |-> link_stop_o && !irq_o && !wake_o)
		else $error("activity in halt");
	// A request seen while the core waits must also wake it; outside Wait no wake is owed
	irq_wake_a: assert property (irq_o && wait_mode_i |-> wake_o)
		else $error("request in wait without wake");
endmodule // uart_status_control_checker

bind uart_status_control uart_status_control_checker #(.ADDR_W(ADDR_W)) uart_status_control_checker_i (.*);

// ### verif/uart_far_end.sv
// Purpose: Far end of the serial line: frame timing and received words.
// Assumes: A frame lasts FRAME_CYC clocks after a load.
// Notes:   Released word lines show the inverse of the last word.
`timescale 1ns/1ns

module uart_far_end #(
	parameter int FRAME_CYC = 6
) (
	input  wire logic       clk_i,
	input  wire logic       shift_load_i,
	output logic            shift_ready_o,
	output logic            tx_busy_o,
	output logic            tx_frame_done_o,
	output logic            tx_frame_data_o,
	output logic            rx_busy_o,
	output logic            rx_word_valid_o,
	output logic      [8:0] rx_word_o,
	output logic            rx_noise_o,
	output logic            rx_framing_o,
	output logic            idle_line_o
);
	int cnt;
	bit pre;

	// ==========================================
	// Transmit side
	always @(posedge clk_i) begin
		if (shift_load_i)
			cnt <= FRAME_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign shift_ready_o   = cnt == 0;
	assign tx_busy_o       = cnt != 0;
	// A preamble ends a frame that carries no data
	assign tx_frame_done_o = cnt == 1 || pre;
	assign tx_frame_data_o = !pre;

	task automatic preamble();
		@(posedge clk_i);
		pre <= 1'b1;
		@(posedge clk_i);
		pre <= 1'b0;
	endtask

	// ==========================================
	// Receive side
	initial begin
		{rx_busy_o, rx_word_valid_o, rx_noise_o, rx_framing_o, idle_line_o} = '0;
		rx_word_o = 9'h1FF;
	end

	task automatic send(input logic [8:0] w, input logic n, input logic f);
		@(posedge clk_i);
		{rx_busy_o, rx_word_valid_o, rx_noise_o, rx_framing_o} <= {2'b11, n, f};
		rx_word_o <= w;
		@(posedge clk_i);
		{rx_busy_o, rx_word_valid_o, rx_noise_o, rx_framing_o} <= 4'h0;
		rx_word_o <= ~w;
	endtask

	task automatic idle();
		@(posedge clk_i);
		idle_line_o <= 1'b1;
		@(posedge clk_i);
		idle_line_o <= 1'b0;
	endtask
endmodule // uart_far_end

// ### verif/test_uart_status_control.sv
// Purpose: Self-checking bench of the serial status block.
// Assumes: Offsets 0 status, 1 data, 2 control one.
// Notes:   Table rows cover transmit formats; the rest is by hand.
`timescale 1ns/1ns

module test_uart_status_control;
	typedef struct {logic [7:0] c; logic [7:0] d; logic [8:0] w;} row_t;

	logic       clk_i, reset_i, wr_i, rd_i;
	logic [1:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic       tx_empty_irq_enable_i, tx_done_irq_enable_i, rx_irq_enable_i;
	logic       quiet_line_irq_enable_i, global_irq_unmask_i, wait_mode_i, halt_mode_i;
	logic       tx_busy_i, rx_busy_i, shift_ready_i, shift_load_o, tx_frame_done_i;
	logic       tx_frame_data_i, rx_word_valid_i, rx_noise_i, rx_framing_i, idle_line_i;
	logic [8:0] shift_word_o, rx_word_i;
	logic       word_nine_o, wake_address_mark_o, parity_enable_o, parity_odd_select_o;
	logic       link_stop_o, irq_o, wake_o;
	int         mismatches, num_checks;
	row_t       rows [6] = '{'{8'h00, 8'hA5, 9'h0A5}, '{8'h06, 8'h35, 9'h0B5},
		'{8'h04, 8'h35, 9'h035}, '{8'h50, 8'h12, 9'h112}, '{8'h54, 8'hB5, 9'h1B5},
		'{8'h08, 8'h5A, 9'h05A}};

	uart_status_control uart_status_control_i (.*);
	uart_far_end uart_far_end_i (.clk_i(clk_i), .shift_load_i(shift_load_o),
		.shift_ready_o(shift_ready_i), .tx_busy_o(tx_busy_i),
		.tx_frame_done_o(tx_frame_done_i), .tx_frame_data_o(tx_frame_data_i),
		.rx_busy_o(rx_busy_i), .rx_word_valid_o(rx_word_valid_i), .rx_word_o(rx_word_i),
		.rx_noise_o(rx_noise_i), .rx_framing_o(rx_framing_i), .idle_line_o(idle_line_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", {1'b0, e}, {1'b0, rdata_o});
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wait_frame();
		int n;
		for (n = 0; n < 40 && tx_frame_done_i !== 1'b1; n++)
			@(posedge clk_i) #1;
		if (n == 40) begin
			mismatches++;
			$display("CHECK FAILED frame_done expected 1 seen %b", tx_frame_done_i);
			end_of_test();
		end
	endtask

	initial begin
		{addr_i, wdata_i, wr_i, rd_i, wait_mode_i, halt_mode_i} = '0;
		{tx_empty_irq_enable_i, tx_done_irq_enable_i, rx_irq_enable_i} = '0;
		{quiet_line_irq_enable_i, global_irq_unmask_i} = '0;
		reset_i = 1'b1;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		wr(2'h0, 8'hFF);
		wr(2'h1, 8'h77);
		rd(2'h0, 8'hC0);
		rd(2'h2, 8'h00);
		rd(2'h3, 8'h00);
		$display("reset test done");
		foreach (rows[k]) begin
			wr(2'h2, rows[k].c);
			rd(2'h2, rows[k].c);
			chk("format", 9'(rows[k].c[4:1]), {word_nine_o, wake_address_mark_o, parity_enable_o, parity_odd_select_o});
			rd(2'h0, 8'hC0);
			wr(2'h1, rows[k].d);
			uart_far_end_i.preamble();
			rd(2'h0, 8'h80);
			chk("word", rows[k].w, shift_word_o);
			wait_frame();
			rd(2'h0, 8'hC0);
			$display("row %0d done", k);
		end
		wr(2'h2, 8'h10);
		uart_far_end_i.send(9'h13C, 1'b0, 1'b0);
		rd(2'h2, 8'h90);
		rd(2'h0, 8'hE0);
		rd(2'h1, 8'h3C);
		rd(2'h0, 8'hC0);
		uart_far_end_i.send(9'h011, 1'b0, 1'b0);
		uart_far_end_i.send(9'h022, 1'b0, 1'b1);
		rd(2'h0, 8'hE8);
		rd(2'h1, 8'h11);
		rd(2'h0, 8'hC0);
		$display("receive test done");
		@(posedge clk_i);
		rx_irq_enable_i <= 1'b1;
		global_irq_unmask_i <= 1'b1;
		uart_far_end_i.send(9'h055, 1'b1, 1'b0);
		#1 chk("irq", 9'h1, {8'h0, irq_o});
		@(posedge clk_i);
		global_irq_unmask_i <= 1'b0;
		wait_mode_i <= 1'b1;
		#1 chk("irq wake", 9'h1, {7'h0, irq_o, wake_o});
		@(posedge clk_i);
		global_irq_unmask_i <= 1'b1;
		halt_mode_i <= 1'b1;
		#1 chk("halt", 9'h1, {6'h0, irq_o, wake_o, link_stop_o});
		@(posedge clk_i);
		halt_mode_i <= 1'b0;
		rd(2'h0, 8'hE4);
		rd(2'h1, 8'h55);
		#1 chk("irq", 9'h0, {8'h0, irq_o});
		@(posedge clk_i);
		rx_irq_enable_i <= 1'b0;
		wr(2'h2, 8'h15);
		uart_far_end_i.send(9'h135, 1'b0, 1'b0);
		#1 chk("irq", 9'h1, {8'h0, irq_o});
		rd(2'h0, 8'hE1);
		rd(2'h1, 8'h35);
		@(posedge clk_i);
		quiet_line_irq_enable_i <= 1'b1;
		uart_far_end_i.idle();
		#1 chk("irq", 9'h1, {8'h0, irq_o});
		rd(2'h0, 8'hD0);
		rd(2'h1, 8'h35);
		uart_far_end_i.idle();
		rd(2'h0, 8'hC0);
		@(posedge clk_i);
		quiet_line_irq_enable_i <= 1'b0;
		tx_empty_irq_enable_i <= 1'b1;
		#1 chk("irq", 9'h1, {8'h0, irq_o});
		@(posedge clk_i);
		tx_empty_irq_enable_i <= 1'b0;
		tx_done_irq_enable_i <= 1'b1;
		#1 chk("irq", 9'h1, {8'h0, irq_o});
		wr(2'h2, 8'h20);
		repeat (2) @(posedge clk_i);
		#1 chk("stop", 9'h1, {8'h0, link_stop_o});
		uart_far_end_i.send(9'h0AA, 1'b0, 1'b0);
		rd(2'h0, 8'hC0);
		wr(2'h2, 8'h00);
		@(posedge clk_i) #1 chk("stop", 9'h0, {8'h0, link_stop_o});
		$display("interrupt and power test done");
		end_of_test();
	end
endmodule // test_uart_status_control
